// >>> sfp_ctrl.sv
// Purpose: power mode, write enable and protection checks of a flash
// Assumes: link logic decodes commands; sector count parameterised
// Notes: link side runs on serial clock, core side on ref_clk
`timescale 1ns/10ps
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int SECTORS = 4
) (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link
  input wire logic link_clk,
  input wire logic select_n,
  input wire sfp_req_s req,
  input wire logic req_end,
  // Pins and status bits
  input wire logic top_sector_lock_n,
  input wire logic write_protect_n,
  input wire logic has_tsl,
  input wire logic [1:0] range_protect_in,
  input wire logic status_lock_in,
  input wire logic cycle_busy,
  // Results
  output sfp_rsp_s rsp,
  output logic start_cycle,
  output logic write_enable_latch,
  output logic [1:0] range_protect_q,
  output logic status_lock_bit,
  output sfp_pwr_e pwr_state
);

  localparam int SW = $clog2(SECTORS);

  // ****************************************
  // Link side: bit count and command capture
  // ****************************************
  logic [2:0] bitcnt_q, bitcnt_d;
  logic cmd_tog_q, cmd_tog_d;
  sfp_req_s held_q, held_d;
  logic aligned_q, aligned_d;

  always_comb begin
    bitcnt_d = bitcnt_q + 3'h1;
    cmd_tog_d = cmd_tog_q;
    held_d = held_q;
    aligned_d = aligned_q;
    if (req_end) begin
      cmd_tog_d = ~cmd_tog_q;
      held_d = req;
      // Count the end edge itself
      aligned_d = (bitcnt_d == BIT_ZERO);
    end
  end

  // Counter cleared by the frame's own deselect so no edge is needed after it
  always_ff @(posedge link_clk or posedge select_n) begin
    if (select_n) begin
      bitcnt_q <= BIT_ZERO;
    end else begin
      bitcnt_q <= bitcnt_d;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_tog_q <= 1'b0;
      held_q <= '0;
      aligned_q <= 1'b0;
    end else begin
      cmd_tog_q <= cmd_tog_d;
      held_q <= held_d;
      aligned_q <= aligned_d;
    end
  end

  // ****************************************
  // Crossings
  // ****************************************
  logic tog_s, sel_n_s, tsl_n_s, wp_n_s;
  sfp_sync #(.W(4)) u_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .d({cmd_tog_q, select_n, top_sector_lock_n, write_protect_n}),
    .q({tog_s, sel_n_s, tsl_n_s, wp_n_s})
  );
  // Held command is stable through the two synchroniser stages before it is sampled
  logic tog_seen_q, tog_seen_d;
  logic cmd_pulse;
  assign cmd_pulse = tog_s ^ tog_seen_q;

  // ****************************************
  // Protection decode
  // ****************************************
  function automatic logic range_hit(input logic [1:0] bp,
                                     input logic [SW-1:0] sec);
    logic hit;
    hit = 1'b0;
    case (bp)
      BP_NONE: hit = 1'b0;
      BP_Q: hit = (SECTORS == 2) ? (sec == SW'(SECTORS - 1))
                                 : (sec == SW'(SECTORS - 1));
      BP_H: hit = (sec >= SW'(SECTORS / 2));
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  logic [SW-1:0] sector;
  logic top_hit;
  assign sector = held_q.addr[SECTOR_SHIFT +: SW];
  assign top_hit = (held_q.addr[ADDR_W-1:PAGE_SHIFT]
                    >= (ADDR_W-PAGE_SHIFT)'(SECTORS*TOP_PAGES - TOP_PAGES));

  // ****************************************
  // Core state
  // ****************************************
  logic [1:0] lock_q [SECTORS];
  logic [1:0] lock_d [SECTORS];
  logic wel_q, wel_d;
  logic [1:0] bp_q, bp_d;
  logic status_lock_bit_q, status_lock_bit_d;
  sfp_pwr_e pwr_q, pwr_d;
  sfp_rsp_s rsp_q, rsp_d;
  logic start_q, start_d;
  logic loaded_q, loaded_d;

  logic is_mod, addr_mod, blocked, legal;
  always_comb begin
    is_mod = held_q.cmd inside {SFP_PWRITE, SFP_PPROG, SFP_PCLR,
                                SFP_SSCLR, SFP_SCLR, SFP_BCLR, SFP_LKWR,
                                SFP_STWR};
    addr_mod = held_q.cmd inside {SFP_PWRITE, SFP_PPROG, SFP_PCLR,
                                  SFP_SSCLR, SFP_SCLR};
    blocked = 1'b0;
    if (addr_mod) begin
      blocked = (has_tsl && !tsl_n_s && top_hit)
                || lock_q[sector][0]
                || range_hit(bp_q, sector);
    end
    if (held_q.cmd == SFP_BCLR) begin
      blocked = (bp_q != BP_NONE);
    end
    legal = aligned_q && !cycle_busy && (!is_mod || wel_q);
  end

  always_comb begin
    lock_d = lock_q;
    wel_d = wel_q;
    bp_d = bp_q;
    status_lock_bit_d = status_lock_bit_q;
    pwr_d = pwr_q;
    rsp_d = '{accepted: 1'b0, refused: 1'b0, lock_rd: rsp_q.lock_rd};
    start_d = 1'b0;
    tog_seen_d = tog_s;
    loaded_d = 1'b1;
    if (!loaded_q) begin
      bp_d = range_protect_in;
      status_lock_bit_d = status_lock_in;
    end
    if (cmd_pulse) begin
      if (pwr_q == SFP_DEEP && held_q.cmd != SFP_WAKE) begin
        rsp_d.refused = 1'b1;
      end else if (!legal || blocked) begin
        rsp_d.refused = 1'b1;
      end else begin
        rsp_d.accepted = 1'b1;
        case (held_q.cmd)
          SFP_WRITE_ENABLE_CMD: wel_d = 1'b1;
          SFP_WRITE_DISABLE_CMD: wel_d = 1'b0;
          SFP_PWRITE, SFP_PPROG, SFP_PCLR, SFP_SSCLR, SFP_SCLR,
          SFP_BCLR: begin
            wel_d = 1'b0;
            start_d = 1'b1;
          end
          SFP_LKWR: begin
            wel_d = 1'b0;
            if (!lock_q[sector][1]) begin
              lock_d[sector] = held_q.lock_data;
            end
          end
          SFP_LKRD: rsp_d.lock_rd = lock_q[sector];
          SFP_STWR: begin
            wel_d = 1'b0;
            if (!(status_lock_bit_q && !wp_n_s)) begin
              {status_lock_bit_d, bp_d} = held_q.status_data;
            end
          end
          SFP_DSLP: pwr_d = SFP_DEEP;
          SFP_WAKE: pwr_d = SFP_STANDBY;
          default: rsp_d.accepted = 1'b1;
        endcase
      end
    end
    if (pwr_d != SFP_DEEP) begin
      if (!sel_n_s || start_d || cycle_busy) begin
        pwr_d = SFP_ACTIVE;
      end else begin
        pwr_d = SFP_STANDBY;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < SECTORS; i++) begin
        lock_q[i] <= LOCK_RST;
      end
      wel_q <= 1'b0;
      bp_q <= BP_NONE;
      status_lock_bit_q <= 1'b0;
      pwr_q <= SFP_STANDBY;
      rsp_q <= '0;
      start_q <= 1'b0;
      tog_seen_q <= 1'b0;
      loaded_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
      wel_q <= wel_d;
      bp_q <= bp_d;
      status_lock_bit_q <= status_lock_bit_d;
      pwr_q <= pwr_d;
      rsp_q <= rsp_d;
      start_q <= start_d;
      tog_seen_q <= tog_seen_d;
      loaded_q <= loaded_d;
    end
  end

  assign rsp = rsp_q;
  assign start_cycle = start_q;
  assign write_enable_latch = wel_q;
  assign range_protect_q = bp_q;
  assign status_lock_bit = status_lock_bit_q;
  assign pwr_state = pwr_q;

  // ****************************************
  // Checks
  // ****************************************
  a_deep_no_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pwr_q == SFP_DEEP |=> !start_q)
    else $error("cycle started in deep power-down");
  a_wel_needed: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start_q |-> $past(wel_q))
    else $error("cycle started without write enable");
  a_wel_clears: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start_q |-> !wel_q)
    else $error("enable latch not cleared");
  a_bulk_guard: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_pulse && held_q.cmd == SFP_BCLR && bp_q != BP_NONE |=> !start_q)
    else $error("bulk clear accepted while protected");
  a_lockdown_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    lock_q[SECTORS-1][1]
    |=> lock_q[SECTORS-1] == $past(lock_q[SECTORS-1]))
    else $error("locked-down sector changed");
  a_sel_active: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !sel_n_s && pwr_q != SFP_DEEP && !(cmd_pulse && held_q.cmd == SFP_DSLP)
    |=> pwr_q == SFP_ACTIVE)
    else $error("selected but not active");
  a_busy_active: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cycle_busy && pwr_q != SFP_DEEP |=> pwr_q != SFP_STANDBY)
    else $error("standby during internal cycle");
  a_refuse_none: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rsp_q.refused |-> !start_q)
    else $error("refused command started cycle");
  a_lock_block: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_pulse && addr_mod && lock_q[sector][0] |=> !start_q)
    else $error("write-locked sector modified");

endmodule // sfp_ctrl

// >>> sfp_ctrl_tb.sv
// Purpose: self-checking bench for sfp_ctrl
// Assumes: four sectors, top-lock variant present
// Notes: table rows first, then hand-written awkward cases
`timescale 1ns/10ps
module sfp_ctrl_tb;
  import sfp_pkg::*;
  // ***************
  // Signals
  // ***************
  typedef struct {
    sfp_cmd_e c;
    logic [23:0] a;
    logic [2:0] d;
    int nb;
    logic [1:0] aw;
  } sfp_row_s;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  logic top_sector_lock_n = 1'h1;
  logic write_protect_n = 1'h1;
  logic cycle_busy = 1'h0;
  logic link_clk;
  logic select_n;
  sfp_req_s req;
  logic req_end;
  sfp_rsp_s rsp;
  logic start_cycle;
  logic write_enable_latch;
  logic [1:0] range_protect_q;
  logic status_lock_bit;
  sfp_pwr_e pwr_state;
  logic seen = 1'h0;
  logic got = 1'h0;
  logic st = 1'h0;
  int n_errors = 0;
  int compares = 0;
  logic [1:0] bp_in = 2'h0;
  // Each row: command, address, data, clocks, {accepted, latch after}
  sfp_row_s rows [28] = '{
    '{SFP_PPROG, 24'h0, 3'h0, 8, 2'h0},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 7, 2'h0},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_PPROG, 24'h0, 3'h0, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_LKWR, 24'h10000, 3'h1, 8, 2'h2},
    '{SFP_LKRD, 24'h10000, 3'h1, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_PCLR, 24'h10000, 3'h0, 8, 2'h1},
    '{SFP_SSCLR, 24'h0, 3'h0, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_STWR, 24'h0, 3'h1, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_PWRITE, 24'h30000, 3'h0, 8, 2'h1},
    '{SFP_SCLR, 24'h20000, 3'h0, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_BCLR, 24'h0, 3'h0, 8, 2'h1},
    '{SFP_WRITE_DISABLE_CMD, 24'h0, 3'h0, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_STWR, 24'h0, 3'h2, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_PPROG, 24'h20000, 3'h0, 8, 2'h1},
    '{SFP_PPROG, 24'h0, 3'h0, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_STWR, 24'h0, 3'h3, 8, 2'h2},
    '{SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3},
    '{SFP_PPROG, 24'h0, 3'h0, 8, 2'h1},
    '{SFP_STWR, 24'h0, 3'h0, 8, 2'h2}};

  always #5 ref_clk = ~ref_clk;

  sfp_master sfp_master_i (.link_clk(link_clk), .select_n(select_n),
    .req(req), .req_end(req_end));

  sfp_ctrl #(.SECTORS(4)) sfp_ctrl_i (.ref_clk(ref_clk),
    .reset_n(reset_n), .link_clk(link_clk), .select_n(select_n),
    .req(req), .req_end(req_end),
    .top_sector_lock_n(top_sector_lock_n),
    .write_protect_n(write_protect_n), .has_tsl(1'h1),
    .range_protect_in(bp_in), .status_lock_in(1'h0),
    .cycle_busy(cycle_busy), .rsp(rsp), .start_cycle(start_cycle),
    .write_enable_latch(write_enable_latch),
    .range_protect_q(range_protect_q),
    .status_lock_bit(status_lock_bit), .pwr_state(pwr_state));

  // Pulses last one cycle, so they are caught here as they pass
  always @(posedge ref_clk) begin
    if (rsp.accepted || rsp.refused) begin
      seen <= 1'h1;
      got <= rsp.accepted;
    end
    st <= st | start_cycle;
  end
  // ***************
  // Tasks
  // ***************
  task automatic conclude();
    $display("Checks %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'h0;
    sfp_master_i.tick();
    repeat (5) @(posedge ref_clk);
    chk(write_enable_latch, 4'h0);
    reset_n <= 1'h1;
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic op(input sfp_cmd_e c, input logic [23:0] a,
      input logic [2:0] d, input int nb, input logic [1:0] aw);
    int k;
    seen = 1'h0;
    st = 1'h0;
    sfp_master_i.frame(sfp_req_s'{c, a, d[1:0], d}, nb);
    for (k = 0; k < 20 && !seen; k++) @(posedge ref_clk);
    if (!seen) begin
      n_errors++;
      conclude();
    end
    chk(got, aw[1]);
    repeat (2) @(posedge ref_clk);
    chk(write_enable_latch, aw[0]);
    if (c == SFP_LKRD) chk(rsp.lock_rd, d[1:0]);
    if (c inside {[SFP_PWRITE:SFP_BCLR]}) chk(st, aw[1]);
    repeat (6) @(posedge ref_clk);
  endtask
  // ***************
  // Sequence
  // ***************
  initial begin
    int k;
    do_reset();
    foreach (rows[i])
      op(rows[i].c, rows[i].a, rows[i].d, rows[i].nb, rows[i].aw);
    op(SFP_DSLP, 24'h0, 3'h0, 8, 2'h2);
    chk(pwr_state, SFP_DEEP);
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h0);
    op(SFP_WAKE, 24'h0, 3'h0, 8, 2'h2);
    chk(pwr_state == SFP_DEEP, 4'h0);
    cycle_busy <= 1'h1;
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h0);
    chk(pwr_state, SFP_ACTIVE);
    cycle_busy <= 1'h0;
    for (k = 0; k < 20 && pwr_state !== SFP_STANDBY; k++)
      @(posedge ref_clk);
    chk(pwr_state, SFP_STANDBY);
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3);
    op(SFP_LKWR, 24'h30000, 3'h3, 8, 2'h2);
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3);
    // Locked-down write is taken but leaves the bits alone
    op(SFP_LKWR, 24'h30000, 3'h0, 8, 2'h2);
    op(SFP_LKRD, 24'h30000, 3'h3, 8, 2'h2);
    bp_in <= 2'h1;
    do_reset();
    chk(range_protect_q, 4'h1);
    op(SFP_LKRD, 24'h30000, 3'h0, 8, 2'h2);
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3);
    op(SFP_STWR, 24'h0, 3'h4, 8, 2'h2);
    chk(status_lock_bit, 4'h1);
    write_protect_n <= 1'h0;
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3);
    // Frozen status write is taken but leaves the bits alone
    op(SFP_STWR, 24'h0, 3'h0, 8, 2'h2);
    chk(status_lock_bit, 4'h1);
    write_protect_n <= 1'h1;
    top_sector_lock_n <= 1'h0;
    op(SFP_WRITE_ENABLE_CMD, 24'h0, 3'h0, 8, 2'h3);
    op(SFP_PPROG, 24'h3FF00, 3'h0, 8, 2'h1);
    op(SFP_PPROG, 24'h2FE00, 3'h0, 8, 2'h2);
    top_sector_lock_n <= 1'h1;
    conclude();
  end
endmodule // sfp_ctrl_tb

// >>> sfp_master.sv
// Purpose: serial master model that sends framed requests
// Assumes: link clock idles low and stands still between frames
// Notes: released request lines show the inverse of the last value
`timescale 1ns/10ps
module sfp_master
  import sfp_pkg::*;
(
  // Link side
  output logic link_clk,
  output logic select_n,
  output sfp_req_s req,
  output logic req_end
);
  initial begin
    link_clk = 1'h0;
    select_n = 1'h1;
    req = '1;
    req_end = 1'h0;
  end

  // Single pulse while deselected, so reset sees a link edge
  task automatic tick();
    #3 link_clk = 1'h1;
    #3 link_clk = 1'h0;
  endtask

  // Frame of nb clocks; the request is valid on the last edge
  task automatic frame(input sfp_req_s r, input int nb);
    select_n = 1'h0;
    req = r;
    #4;
    for (int i = 1; i <= nb; i++) begin
      req_end = (i == nb);
      #3 link_clk = 1'h1;
      #3 link_clk = 1'h0;
    end
    req_end = 1'h0;
    req = sfp_req_s'(~r);
    #2 select_n = 1'h1;
  endtask
endmodule // sfp_master

// >>> sfp_pkg.sv
// Purpose: constants and types for the serial flash protect/power block
// Assumes: instructions are decoded outside this block
// Notes: shared by sfp_ctrl, sfp_master and sfp_ctrl_tb
//
// Operation
// - Chip-select low means selected and active
// - Deselected stays active until internal cycle ends
// - Deep-sleep command enters power-down until release
// - In power-down ignore everything except release
// - Modify commands need clock count multiple of eight
// - Modify commands refused while enable latch clear
// - Listed modify commands clear enable latch
// - Reset low freezes and resets control logic
// - Top-sector lock low makes top 256 pages read-only
// - Write-protect low with status lock freezes bits
// - One lock register per 64-Kbyte sector
// - Lock registers readable and writable by commands
// - Write-lock bit set blocks sector modification
// - Lock-down bit freezes sector lock until reset
// - Lock bits volatile, cleared to zero at reset
// - Four-sector block-protect coding of protected sectors
// - Two-sector block-protect coding of protected sectors
// - Bulk clear only when both protect bits zero
// - Sector index from upper address bits, 65536 bytes
package sfp_pkg;

  localparam int ADDR_W = 24;
  localparam int SECTOR_SHIFT = 16;
  localparam int PAGE_SHIFT = 8;
  localparam int TOP_PAGES = 256;
  localparam int BYTE_BITS = 3;
  localparam logic [2:0] BIT_ZERO = 3'h0;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_Q = 2'h1;
  localparam logic [1:0] BP_H = 2'h2;
  localparam logic [1:0] LOCK_RST = 2'h0;

  // Commands as decoded by the instruction front end
  typedef enum logic [3:0] {
    SFP_NONE,
    SFP_WRITE_ENABLE_CMD,
    SFP_WRITE_DISABLE_CMD,
    SFP_PWRITE,
    SFP_PPROG,
    SFP_PCLR,
    SFP_SSCLR,
    SFP_SCLR,
    SFP_BCLR,
    SFP_LKWR,
    SFP_LKRD,
    SFP_STWR,
    SFP_DSLP,
    SFP_WAKE
  } sfp_cmd_e;

  typedef enum logic [1:0] {
    SFP_STANDBY,
    SFP_ACTIVE,
    SFP_DEEP
  } sfp_pwr_e;

  typedef struct packed {
    sfp_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [1:0] lock_data;
    logic [2:0] status_data;
  } sfp_req_s;

  typedef struct packed {
    logic accepted;
    logic refused;
    logic [1:0] lock_rd;
  } sfp_rsp_s;

endpackage

// >>> sfp_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level from another domain
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module sfp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule // sfp_sync
